//--- rtl/adc_conversion_control.sv
/*
 * Converter control: APB register file, conversion clock, start/halt
 * sequencing, sleep handling, special event trigger and interrupt.
 * Assumes an APB master on clk; comparator and RC clock pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr,
	// Core and compare unit
	input  wire logic                   sleep_active,
	input  wire logic [3:0]             compare_mode_field,
	input  wire logic                   special_event,
	output logic                        timer_counter_reset,
	output logic                        wake_request,
	output logic                        irq,
	// Analog front end
	input  wire logic                   comparator_in,
	input  wire logic                   rc_clock_in,
	output logic                        analog_power,
	output logic                        sample_switch,
	output logic [3:0]                  channel_select,
	output logic [RESULT_BITS-1:0]      dac_trial_out
);
	// ==========================================================
	// Registers
	logic [7:0]  interrupt_control_q;
	logic [7:0]  pie_q;
	logic        irq_flag_q;
	logic [7:0]  control0_q;
	logic        go_q;
	logic [7:0]  voltage_reference_control_q;
	logic [7:0]  analog_pin_select_q;
	logic [7:0]  control1_q;
	logic [7:0]  result_hi_q;
	logic [7:0]  result_lo_q;

	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;

	logic [1:0]  cmp_sync_q;
	logic [2:0]  rc_sync_q;
	logic [5:0]  div_cnt_q;
	logic        tad_tick;
	logic [3:0]  delay_cnt_q;

	conv_state_type state_q;
	conv_state_type state_d;

	sar_status_type sar;
	logic [RESULT_BITS-1:0] dac_trial;

	logic        wr_req;
	logic        rd_done;
	logic [9:0]  idx;
	logic [7:0]  wbyte;
	logic [7:0]  rd_mux;
	logic        rd_hit;
	logic        module_on;
	logic        rc_select;
	logic        sleep_off;
	logic        powered;
	logic        trigger_start;
	logic        start_now;
	logic        conv_start;
	logic        kill;
	logic        halt;
	logic [15:0] justified;

	assign idx       = paddr[11:2];
	assign wbyte     = pwdata[7:0];
	assign wr_req    = psel && penable && pready_q && pwrite;
	assign rd_done   = psel && penable && pready_q && !pwrite;
	assign module_on = control0_q[MODULE_ON_BIT];
	assign rc_select = control0_q[CLOCK_SELECT_MSB:CLOCK_SELECT_LSB] == CLOCK_SELECT_RC;
	assign sleep_off = sleep_active && !rc_select;
	assign powered   = module_on && !sleep_off;

	// ==========================================================
	// Read multiplexer
	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 8'h00;
		unique case (idx)
			IDX_INTERRUPT_CONTROL:     rd_mux = interrupt_control_q;
			IDX_PERIPHERAL_IRQ_FLAGS:  rd_mux[CONVERTER_IRQ_BIT] = irq_flag_q;
			IDX_RESULT_HIGH:           rd_mux = result_hi_q;
			IDX_CONTROL_PRIMARY: begin
				rd_mux = control0_q;
				rd_mux[GO_BIT] = go_q;
			end
			IDX_PERIPHERAL_IRQ_ENABLE: rd_mux = pie_q;
			IDX_REFERENCE_CONTROL:     rd_mux = voltage_reference_control_q;
			IDX_ANALOG_PIN_SELECT:     rd_mux = analog_pin_select_q;
			IDX_RESULT_LOW:            rd_mux = result_lo_q;
			IDX_CONTROL_SECONDARY:     rd_mux = control1_q;
			default:                   rd_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// APB handshake: one wait-free access phase, answer prepared in setup
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (psel && !penable && !pready_q) begin
			pready_q  <= 1'b1;
			pslverr_q <= !rd_hit;
			prdata_q  <= {24'h00_0000, rd_mux};
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ==========================================================
	// Control and configuration registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			interrupt_control_q   <= RST_INTERRUPT_CONTROL;
			pie_q      <= RST_IRQ_ENABLES;
			control0_q <= RST_CONTROL_PRIMARY;
			voltage_reference_control_q   <= RST_REFERENCE_CONTROL;
			analog_pin_select_q    <= RST_ANALOG_PIN_SELECT;
			control1_q <= RST_CONTROL_SECONDARY;
		end else if (wr_req) begin
			unique case (idx)
				IDX_INTERRUPT_CONTROL:     interrupt_control_q <= wbyte;
				IDX_PERIPHERAL_IRQ_ENABLE: pie_q <= wbyte;
				IDX_CONTROL_PRIMARY: begin
					control0_q <= wbyte;
					control0_q[GO_BIT] <= 1'b0;
				end
				IDX_REFERENCE_CONTROL:     voltage_reference_control_q <= wbyte & REFERENCE_MASK;
				IDX_ANALOG_PIN_SELECT:     analog_pin_select_q <= wbyte;
				IDX_CONTROL_SECONDARY:     control1_q <= wbyte & SECONDARY_MASK;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Result bytes: no reset branch, so any reset leaves them as they were
	assign justified = control1_q[RESULT_JUSTIFY_BIT] ?
		{4'h0, sar.result} : {sar.result, 4'h0};

	always_ff @(posedge clk) begin
		if (sar.done) begin
			result_hi_q <= justified[15:8];
			result_lo_q <= justified[7:0];
		end else if (wr_req && idx == IDX_RESULT_HIGH) begin
			result_hi_q <= wbyte;
		end else if (wr_req && idx == IDX_RESULT_LOW) begin
			result_lo_q <= wbyte;
		end
	end

	// ==========================================================
	// In-progress bit
	assign trigger_start = special_event && compare_mode_field == COMPARE_SPECIAL_EVENT;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			go_q <= 1'b0;
		end else if (trigger_start && module_on) begin
			go_q <= 1'b1;
		end else if (wr_req && idx == IDX_CONTROL_PRIMARY) begin
			go_q <= wbyte[GO_BIT] && wbyte[MODULE_ON_BIT];
		end else if (sar.done || (go_q && !powered)) begin
			go_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			timer_counter_reset <= 1'b0;
		end else begin
			timer_counter_reset <= trigger_start;
		end
	end

	// ==========================================================
	// Pin synchronisers; the third stage of the RC clock feeds edge detection only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmp_sync_q <= 2'h0;
			rc_sync_q  <= 3'h0;
		end else begin
			cmp_sync_q <= {cmp_sync_q[0], comparator_in};
			rc_sync_q  <= {rc_sync_q[1:0], rc_clock_in};
		end
	end

	// ==========================================================
	// Conversion clock period
	always_ff @(posedge clk) begin
		if (sys_rst || state_q != CONV_RUN) begin
			div_cnt_q <= 6'h01;
		end else begin
			unique case (control0_q[CLOCK_SELECT_MSB:CLOCK_SELECT_LSB])
				CLOCK_SELECT_DIV2:  div_cnt_q <= (div_cnt_q >= DIV2_CLKS) ? 6'h01 : div_cnt_q + 6'h01;
				CLOCK_SELECT_DIV8:  div_cnt_q <= (div_cnt_q >= DIV8_CLKS) ? 6'h01 : div_cnt_q + 6'h01;
				CLOCK_SELECT_DIV32: div_cnt_q <= (div_cnt_q >= DIV32_CLKS) ? 6'h01 : div_cnt_q + 6'h01;
				CLOCK_SELECT_RC:    div_cnt_q <= 6'h01;
			endcase
		end
	end

	always_comb begin
		unique case (control0_q[CLOCK_SELECT_MSB:CLOCK_SELECT_LSB])
			CLOCK_SELECT_DIV2:  tad_tick = div_cnt_q == DIV2_CLKS;
			CLOCK_SELECT_DIV8:  tad_tick = div_cnt_q == DIV8_CLKS;
			CLOCK_SELECT_DIV32: tad_tick = div_cnt_q == DIV32_CLKS;
			CLOCK_SELECT_RC:    tad_tick = rc_sync_q[1] && !rc_sync_q[2];
		endcase
	end

	// ==========================================================
	// Conversion sequencing
	assign start_now  = go_q && powered;
	assign kill       = !powered;
	assign halt       = state_q == CONV_RUN && !go_q;
	assign conv_start = (state_q == CONV_IDLE && start_now && !rc_select) ||
		(state_q == CONV_DELAY && go_q && delay_cnt_q == INSTR_CYCLE_CLKS);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CONV_IDLE: begin
				if (start_now) begin
					state_d = rc_select ? CONV_DELAY : CONV_RUN;
				end
			end
			CONV_DELAY: begin
				if (!start_now) begin
					state_d = CONV_IDLE;
				end else if (delay_cnt_q == INSTR_CYCLE_CLKS) begin
					state_d = CONV_RUN;
				end
			end
			CONV_RUN: begin
				if (kill || sar.done) begin
					state_d = CONV_IDLE;
				end
			end
			default: state_d = CONV_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= CONV_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || state_q != CONV_DELAY) begin
			delay_cnt_q <= 4'h1;
		end else begin
			delay_cnt_q <= delay_cnt_q + 4'h1;
		end
	end

	// Comparator latency of the synchroniser limits accuracy at the fastest clock
	sar_engine u_sar (
		.clk             (clk),
		.sys_rst         (sys_rst),
		.start           (conv_start),
		.halt            (halt),
		.kill            (kill),
		.tad_tick        (tad_tick),
		.comparator_high (cmp_sync_q[1]),
		.status          (sar),
		.dac_trial       (dac_trial)
	);

	// ==========================================================
	// Interrupt flag: a read clears it, a completion in the same cycle wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_flag_q <= 1'b0;
		end else if (sar.done) begin
			irq_flag_q <= 1'b1;
		end else if (rd_done && idx == IDX_PERIPHERAL_IRQ_FLAGS) begin
			irq_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq          <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			irq <= irq_flag_q && pie_q[CONVERTER_IRQ_BIT] &&
				interrupt_control_q[PERIPHERAL_IRQ_ENABLE_BIT] && interrupt_control_q[GLOBAL_IRQ_ENABLE_BIT];
			wake_request <= sar.done && sleep_active && pie_q[CONVERTER_IRQ_BIT];
		end
	end

	// ==========================================================
	// Analog front end drives
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			analog_power   <= 1'b0;
			sample_switch  <= 1'b0;
			channel_select <= 4'h0;
			dac_trial_out  <= '0;
		end else begin
			analog_power   <= powered;
			sample_switch  <= powered && state_q != CONV_RUN;
			channel_select <= {control0_q[1], control0_q[5:3]};
			dac_trial_out  <= dac_trial;
		end
	end

	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign prdata  = prdata_q;
endmodule
`default_nettype wire

//--- rtl/adc_ctrl_pkg.sv
/*
 * Shared constants and types of the converter control block.
 * Assumes a 250 MHz clock that is also the device oscillator.
 */
package adc_ctrl_pkg;
	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [9:0] IDX_INTERRUPT_CONTROL     = 10'h00B;
	localparam logic [9:0] IDX_PERIPHERAL_IRQ_FLAGS  = 10'h00C;
	localparam logic [9:0] IDX_RESULT_HIGH           = 10'h01E;
	localparam logic [9:0] IDX_CONTROL_PRIMARY       = 10'h01F;
	localparam logic [9:0] IDX_PERIPHERAL_IRQ_ENABLE = 10'h08C;
	localparam logic [9:0] IDX_REFERENCE_CONTROL     = 10'h09B;
	localparam logic [9:0] IDX_ANALOG_PIN_SELECT     = 10'h09D;
	localparam logic [9:0] IDX_RESULT_LOW            = 10'h09E;
	localparam logic [9:0] IDX_CONTROL_SECONDARY     = 10'h09F;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLES       = 8'h00;
	localparam logic [7:0] RST_CONTROL_PRIMARY   = 8'h00;
	localparam logic [7:0] RST_REFERENCE_CONTROL = 8'h00;
	localparam logic [7:0] RST_ANALOG_PIN_SELECT = 8'hFF;
	localparam logic [7:0] RST_CONTROL_SECONDARY = 8'h00;

	// ==========================================================
	// Field positions
	localparam int GLOBAL_IRQ_ENABLE_BIT     = 7;
	localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
	localparam int CONVERTER_IRQ_BIT         = 6;
	localparam int CLOCK_SELECT_MSB          = 7;
	localparam int CLOCK_SELECT_LSB          = 6;
	localparam int GO_BIT                    = 2;
	localparam int MODULE_ON_BIT             = 0;
	localparam int RESULT_JUSTIFY_BIT        = 7;
	localparam logic [7:0] REFERENCE_MASK    = 8'hF0;
	localparam logic [7:0] SECONDARY_MASK    = 8'hF0;

	// ==========================================================
	// Conversion clock selections and divisions
	localparam logic [1:0] CLOCK_SELECT_DIV2  = 2'h0;
	localparam logic [1:0] CLOCK_SELECT_DIV8  = 2'h1;
	localparam logic [1:0] CLOCK_SELECT_DIV32 = 2'h2;
	localparam logic [1:0] CLOCK_SELECT_RC    = 2'h3;
	localparam logic [5:0] DIV2_CLKS          = 6'h02;
	localparam logic [5:0] DIV8_CLKS          = 6'h08;
	localparam logic [5:0] DIV32_CLKS         = 6'h20;
	localparam logic [3:0] COMPARE_SPECIAL_EVENT = 4'hB;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_PS    = 4000;
	localparam int INSTR_CYCLE_PS   = 16000;
	localparam logic [3:0] INSTR_CYCLE_CLKS = 4'(INSTR_CYCLE_PS / CLK_PERIOD_PS);

	localparam int RESULT_BITS = 12;

	typedef struct packed {
		logic                   busy;
		logic                   done;
		logic [RESULT_BITS-1:0] result;
	} sar_status_type;

	typedef enum logic [2:0] {
		CONV_IDLE  = 3'b001,
		CONV_DELAY = 3'b010,
		CONV_RUN   = 3'b100
	} conv_state_type;
endpackage

//--- rtl/sar_engine.sv
/*
 * Successive approximation sequencer: one setup period, then one
 * result bit per conversion clock period, most significant first.
 * Assumes tad_tick is a one-cycle pulse and comparator_high is already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
module sar_engine
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// Control
	input  wire logic                   start,
	input  wire logic                   halt,
	input  wire logic                   kill,
	input  wire logic                   tad_tick,
	input  wire logic                   comparator_high,
	// Status
	output var sar_status_type          status,
	output logic [RESULT_BITS-1:0]      dac_trial
);
	localparam int IDX_W = $clog2(RESULT_BITS);

	logic                   busy_q;
	logic                   setup_q;
	logic                   done_q;
	logic [IDX_W-1:0]       bit_idx_q;
	logic [RESULT_BITS-1:0] resolved_q;
	logic [RESULT_BITS-1:0] result_q;
	logic [RESULT_BITS-1:0] with_bit;

	always_comb begin
		with_bit = resolved_q;
		with_bit[bit_idx_q] = comparator_high;
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk) begin
		done_q <= 1'b0;
		if (sys_rst || kill) begin
			busy_q     <= 1'b0;
			setup_q    <= 1'b0;
			bit_idx_q  <= '0;
			resolved_q <= '0;
		end else if (start) begin
			busy_q     <= 1'b1;
			setup_q    <= 1'b1;
			bit_idx_q  <= IDX_W'(RESULT_BITS - 1);
			resolved_q <= '0;
		end else if (busy_q && halt) begin
			busy_q   <= 1'b0;
			done_q   <= 1'b1;
			result_q <= resolved_q;
		end else if (busy_q && tad_tick) begin
			if (setup_q) begin
				setup_q <= 1'b0;
			end else begin
				resolved_q <= with_bit;
				if (bit_idx_q == '0) begin
					busy_q   <= 1'b0;
					done_q   <= 1'b1;
					result_q <= with_bit;
				end else begin
					bit_idx_q <= bit_idx_q - 1'b1;
				end
			end
		end
	end

	always_comb begin
		dac_trial = '0;
		if (busy_q && !setup_q) begin
			dac_trial = resolved_q;
			dac_trial[bit_idx_q] = 1'b1;
		end
	end

	assign status = '{busy: busy_q, done: done_q, result: result_q};
endmodule
`default_nettype wire

//--- testbench/adc_ctrl_asserts.sv
/*
 * Port checker for the converter control block.
 * Assumes it is bound to adc_conversion_control and runs on its one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic				clk,
	input wire logic				sys_rst,
	// APB
	input wire logic				psel,
	input wire logic				penable,
	input wire logic				pwrite,
	input wire logic [11:0]			paddr,
	input wire logic [31:0]			pwdata,
	input wire logic				pready,
	input wire logic [31:0]			prdata,
	input wire logic				pslverr,
	// Core and compare unit
	input wire logic				sleep_active,
	input wire logic [3:0]			compare_mode_field,
	input wire logic				special_event,
	input wire logic				timer_counter_reset,
	input wire logic				wake_request,
	input wire logic				irq,
	// Analog front end
	input wire logic				comparator_in,
	input wire logic				rc_clock_in,
	input wire logic				analog_power,
	input wire logic				sample_switch,
	input wire logic [3:0]			channel_select,
	input wire logic [RESULT_BITS-1:0]	dac_trial_out
);
	// ==========================================================
	// Helpers
	logic wr_ctrl;
	assign wr_ctrl = psel && penable && pready && pwrite && paddr == {IDX_CONTROL_PRIMARY, 2'b00};

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Checks
	reset_quiet_a: assert property ($fell(sys_rst) |-> !analog_power && !irq && !pready && dac_trial_out == '0)
		else $error("outputs not idle after reset");
	halt_clears_a: assert property (wr_ctrl && !pwdata[GO_BIT] |-> ##[1:3] dac_trial_out == '0)
		else $error("conversion kept running after halt");
	off_quiet_a: assert property (!analog_power [*2] |-> !sample_switch && dac_trial_out == '0)
		else $error("front end active while off");
	trigger_timer_a: assert property (special_event && compare_mode_field == COMPARE_SPECIAL_EVENT |=> timer_counter_reset)
		else $error("trigger did not reset timer");
	timer_cause_a: assert property (timer_counter_reset |-> $past(special_event) && $past(compare_mode_field) == COMPARE_SPECIAL_EVENT)
		else $error("timer reset without trigger");
	wake_cause_a: assert property (wake_request |-> $past(sleep_active) ##1 !wake_request)
		else $error("wake pulse out of sleep or too long");
	// RC start waits an instruction cycle, so the sample switch stays closed meanwhile
	rc_delay_a: assert property (wr_ctrl && pwdata[7:6] == CLOCK_SELECT_RC && pwdata[GO_BIT] && pwdata[MODULE_ON_BIT]
		|=> ##1 (sample_switch && dac_trial_out == '0) [*3])
		else $error("RC conversion started early");
	apb_ready_a: assert property (psel && !penable |=> pready && penable)
		else $error("no ready in first access cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule

bind adc_conversion_control adc_ctrl_checker u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.sleep_active(sleep_active), .compare_mode_field(compare_mode_field), .special_event(special_event),
	.timer_counter_reset(timer_counter_reset), .wake_request(wake_request), .irq(irq),
	.comparator_in(comparator_in), .rc_clock_in(rc_clock_in), .analog_power(analog_power),
	.sample_switch(sample_switch), .channel_select(channel_select), .dac_trial_out(dac_trial_out));
`default_nettype wire

//--- testbench/adc_conversion_control_tb.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes zero-wait APB answers and conversion clock counts from the package.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module adc_conversion_control_tb
	import adc_ctrl_pkg::*;
;
	logic				clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0]		paddr = '0;
	logic [31:0]		pwdata = '0, prdata;
	logic				pready, pslverr, timer_counter_reset, wake_request, irq, analog_power, sample_switch;
	logic				sleep_active = 0, special_event = 0, comparator_in = 1, rc_clock_in = 0;
	logic [3:0]			compare_mode_field = '0, channel_select;
	logic [RESULT_BITS-1:0]	dac_trial_out;
	logic [7:0]			rdv;
	logic				errv, tmr_seen = 0, wake_seen = 0;
	logic [1:0]			rc_div = '0;
	int					num_errors = 0, n_tests = 0;
	logic [9:0]			ridx [7] = '{IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_IRQ_FLAGS, IDX_CONTROL_PRIMARY,
		IDX_PERIPHERAL_IRQ_ENABLE, IDX_REFERENCE_CONTROL, IDX_ANALOG_PIN_SELECT, IDX_CONTROL_SECONDARY};
	logic [7:0]			rval [7] = '{RST_INTERRUPT_CONTROL, 8'h00, RST_CONTROL_PRIMARY, RST_IRQ_ENABLES,
		RST_REFERENCE_CONTROL, RST_ANALOG_PIN_SELECT, RST_CONTROL_SECONDARY};

	adc_conversion_control DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.sleep_active(sleep_active), .compare_mode_field(compare_mode_field), .special_event(special_event),
		.timer_counter_reset(timer_counter_reset), .wake_request(wake_request), .irq(irq),
		.comparator_in(comparator_in), .rc_clock_in(rc_clock_in), .analog_power(analog_power),
		.sample_switch(sample_switch), .channel_select(channel_select), .dac_trial_out(dac_trial_out));

	// ==========================================================
	// Clocks and pulse catchers
	always #2 clk = ~clk;

	// RC clock runs free so the sleep case sees edges with the core idle
	always @(posedge clk) begin
		rc_div <= rc_div + 2'd1;
		if (rc_div == 2'd2) begin
			rc_div <= '0;
			rc_clock_in <= ~rc_clock_in;
		end
		if (timer_counter_reset === 1'b1)
			tmr_seen <= 1'b1;
		if (wake_request === 1'b1)
			wake_seen <= 1'b1;
	end

	// ==========================================================
	// Bus and helper tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Idle edge after each transfer keeps psel from being driven twice in one step
	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d, output logic [7:0] r, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			num_errors++;
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		apb(1'b1, i, d, rdv, errv);
	endtask

	task automatic rdc(input logic [9:0] i, input logic [7:0] x);
		apb(1'b0, i, 8'h00, rdv, errv);
		`CHK(rdv, x)
	endtask

	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			apb(1'b0, IDX_CONTROL_PRIMARY, 8'h00, rdv, errv);
			k++;
		end while (rdv[GO_BIT] !== 1'b0 && k < 300);
		`CHK(rdv[GO_BIT], 1'b0)
	endtask

	task automatic convert(input logic [7:0] ctl);
		wr(IDX_CONTROL_PRIMARY, ctl);
		wr(IDX_CONTROL_PRIMARY, ctl | 8'h04);
		wait_idle();
	endtask

	task automatic trigger;
		special_event <= 1'b1;
		@(posedge clk);
		special_event <= 1'b0;
		@(posedge clk);
	endtask

	task automatic do_reset;
		sys_rst <= 1'b1;
		cyc(2);
		sys_rst <= 1'b0;
		cyc(1);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		cyc(20000);
		num_errors++;
		final_report();
	end

	// ==========================================================
	// Scenarios
	initial begin
		do_reset();
		for (int i = 0; i < 7; i++)
			rdc(ridx[i], rval[i]);
		apb(1'b0, 10'h001, 8'h00, rdv, errv);
		`CHK({errv, rdv}, 9'h100)
		wr(IDX_PERIPHERAL_IRQ_FLAGS, 8'h40);
		rdc(IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
		wr(IDX_REFERENCE_CONTROL, 8'hFF);
		rdc(IDX_REFERENCE_CONTROL, REFERENCE_MASK);
		// Full conversion, then a masked one at the divide-by-8 clock
		wr(IDX_CONTROL_SECONDARY, 8'h80);
		wr(IDX_PERIPHERAL_IRQ_ENABLE, 8'h40);
		wr(IDX_INTERRUPT_CONTROL, 8'hC0);
		convert(8'h01);
		`CHK(irq, 1'b1)
		rdc(IDX_RESULT_HIGH, 8'h0F);
		rdc(IDX_RESULT_LOW, 8'hFF);
		rdc(IDX_PERIPHERAL_IRQ_FLAGS, 8'h40);
		cyc(2);
		`CHK(irq, 1'b0)
		wr(IDX_PERIPHERAL_IRQ_ENABLE, 8'h00);
		convert(8'h41);
		`CHK(irq, 1'b0)
		rdc(IDX_PERIPHERAL_IRQ_FLAGS, 8'h40);
		do_reset();
		rdc(IDX_RESULT_HIGH, 8'h0F);
		rdc(IDX_RESULT_LOW, 8'hFF);
		rdc(IDX_CONTROL_SECONDARY, 8'h00);
		// Halt midway through the fifth bit keeps four bits
		wr(IDX_CONTROL_SECONDARY, 8'h80);
		wr(IDX_CONTROL_PRIMARY, 8'h9B);
		wr(IDX_CONTROL_PRIMARY, 8'h9F);
		cyc((4 + 1) * int'(DIV32_CLKS) + 14);
		wr(IDX_CONTROL_PRIMARY, 8'h9B);
		rdc(IDX_CONTROL_PRIMARY, 8'h9B);
		`CHK(channel_select, 4'hB)
		rdc(IDX_RESULT_HIGH, 8'h0F);
		rdc(IDX_RESULT_LOW, 8'h00);
		rdc(IDX_PERIPHERAL_IRQ_FLAGS, 8'h40);
		// Sleep with a divided clock aborts
		wr(IDX_CONTROL_PRIMARY, 8'h85);
		cyc(10);
		sleep_active <= 1'b1;
		cyc(4);
		`CHK(analog_power, 1'b0)
		sleep_active <= 1'b0;
		rdc(IDX_CONTROL_PRIMARY, 8'h81);
		rdc(IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
		// Special event trigger, module on then off
		comparator_in <= 1'b0;
		compare_mode_field <= COMPARE_SPECIAL_EVENT;
		wr(IDX_CONTROL_PRIMARY, 8'h01);
		trigger();
		rdc(IDX_CONTROL_PRIMARY, 8'h05);
		wait_idle();
		rdc(IDX_RESULT_LOW, 8'h00);
		rdc(IDX_PERIPHERAL_IRQ_FLAGS, 8'h40);
		wr(IDX_CONTROL_PRIMARY, 8'h00);
		tmr_seen <= 1'b0;
		trigger();
		cyc(1);
		`CHK(tmr_seen, 1'b1)
		rdc(IDX_CONTROL_PRIMARY, 8'h00);
		// RC clock in sleep, with and without the enable
		compare_mode_field <= 4'h0;
		wr(IDX_PERIPHERAL_IRQ_ENABLE, 8'h40);
		for (int k = 0; k < 2; k++) begin
			wake_seen <= 1'b0;
			wr(IDX_CONTROL_PRIMARY, 8'hC1);
			wr(IDX_CONTROL_PRIMARY, 8'hC5);
			sleep_active <= 1'b1;
			for (int n = 0; n < 400 && wake_seen !== 1'b1; n++)
				@(posedge clk);
			sleep_active <= 1'b0;
			`CHK(wake_seen, (k == 0))
			wait_idle();
			rdc(IDX_CONTROL_PRIMARY, 8'hC1);
			rdc(IDX_RESULT_HIGH, 8'h00);
			rdc(IDX_PERIPHERAL_IRQ_FLAGS, 8'h40);
			wr(IDX_PERIPHERAL_IRQ_ENABLE, 8'h00);
		end
		final_report();
	end
endmodule
`default_nettype wire
